// file: itd_consts.svh
// itd_consts.svh: constants of the instruction length and timing decoder
// assumes: included by bare name wherever the decoder constants are needed
`ifndef ITD_CONSTS_SVH
`define ITD_CONSTS_SVH

// spare opcode, executed as the no-operation instruction
`define ITD_OP_SPARE 8'hA5
// no-operation opcode
`define ITD_OP_NOP 8'h00
// direct address bit that selects function registers over data ram
`define ITD_DIR_SFR_BIT 7
// page-local target: number of low address bits replaced
`define ITD_PAGE_BITS 11
// bank register ram address: position of the bank select field
`define ITD_BANK_LSB 3
// reset value of every decoded output
`define ITD_RST_BYTE 8'h00
// widest cycle count of any instruction
`define ITD_MAX_CYCLES 4'h8

`endif

// file: itd_core.sv
// itd_core.sv: opcode length, cycle timing and operand address decoder
// assumes: opcode and operand bytes, pc and bank select arrive from fetch logic
// on mclk_in; a result appears one clock after a sampled request
`timescale 1ns/10ps
`include "itd_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - some counts vary with alignment, flash timing
// - accumulator one-cycle ops; complement takes two
// - xor immediate into direct: 3 bytes, 3
// - direct to direct move: 3 bytes, 3
// - data pointer immediate load: 3 bytes, 3
// - code read via data pointer: 1 byte, 4-7
// - code read via pc: 1 byte, 3
// - external data moves: 1 byte, 3 cycles
// - low nibble exchange swaps bits 3:0, 2
// - carry/zero jumps: 2 not taken, 4-6
// - jump bit and clear: 3 bytes, 3/5-7
// - page call, page jump, short jump: 4-6
// - long call and long jump: 5-7
// - both returns: 1 byte, 6-8 cycles
// - indirect jump: 1 byte, 3-5 cycles
// - compare unequal direct/indirect: 4/6-8
// - compare immediate: 3; taken bank 5-7, acc 6-8
// - decrement jump: direct 3/5-7, bank 2/4-6
// - relative target is next pc plus sext offset
// - direct below 0x80 is ram, else registers
// - page target keeps next pc upper bits
// - long target reaches full 64 kB
// - opcode 0xA5 behaves as no-operation
// - bank register address from bank select
// - not taken two cycles sooner than least taken, three for compare immediate acc
module itd_core #(
  parameter int PC_W = 16  // program counter width
) (
  input  wire logic            mclk_in,     // system clock, 100 MHz
  input  wire logic            reset_in,    // async reset, active high
  input  wire logic            ce_in,       // clock enable, freezes state when low
  input  wire logic            valid_in,    // opcode present this cycle
  input  wire logic [7:0]      opcode_in,   // fetched opcode byte
  input  wire logic [7:0]      op1_in,      // first operand byte
  input  wire logic [7:0]      op2_in,      // second operand byte
  input  wire logic [PC_W-1:0] pc_in,       // address of the opcode byte
  input  wire logic            taken_in,    // evaluated branch condition
  input  wire logic [1:0]      align_in,    // alignment penalty slots
  input  wire logic [1:0]      flash_read_timing_field_in, // flash wait slots
  input  wire logic [1:0]      bank_select_field_in,       // active register bank
  input  wire logic [7:0]      acc_in,      // accumulator value
  input  wire logic [15:0]     data_pointer_pair_in,       // data pointer value
  input  wire logic [7:0]      mem_byte_in, // indirectly addressed ram byte
  output logic                 valid_out,   // decode result present
  output logic [1:0]           len_out,     // instruction byte length
  output logic [3:0]           cycles_out,  // cycles for this execution
  output logic [3:0]           cyc_nt_out,  // base / not-taken count
  output logic [3:0]           cyc_min_out, // least taken count
  output logic [3:0]           cyc_max_out, // most taken count
  output logic                 cond_out,    // conditional branch
  output logic                 tgt_valid_out, // target meaningful
  output logic [15:0]          target_out,  // branch destination
  output logic                 dir_sfr_out, // direct operand hits registers
  output logic [7:0]           bank_addr_out, // bank register ram address
  output logic [7:0]           ptr_addr_out,  // pointer register ram address
  output logic                 nop_out,     // no-operation decoded
  output logic [7:0]           nib_acc_out, // accumulator after nibble exchange
  output logic [7:0]           nib_mem_out  // ram byte after nibble exchange
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check
  if (PC_W != 16) begin : g_pc_check
    $error("itd_core: PC_W must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timing table helpers

  // pack one table entry
  function automatic itd_pkg::itd_info_t mk(input logic [1:0] len, input logic [3:0] nt,
      input logic [3:0] mn, input logic [3:0] mx, input logic cond, input itd_pkg::itd_tgt_t tgt);
    itd_pkg::itd_info_t d;
    d.len = len;
    d.nt = nt;
    d.tmin = mn;
    d.tmax = mx;
    d.cond = cond;
    d.tgt = tgt;
    return d;
  endfunction : mk

  // length and timing of every opcode
  function automatic itd_pkg::itd_info_t decode(input logic [7:0] op);
    itd_pkg::itd_info_t d;
    // column defaults: immediate/direct forms, indirect forms, bank forms
    unique casez (op[3:0])
      4'h4, 4'h5: d = mk(2'h2, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      4'h6, 4'h7: d = mk(2'h1, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      4'b1???: d = mk(2'h1, 4'h1, 4'h1, 4'h1, 1'b0, itd_pkg::ITD_TGT_NONE);
      default: d = mk(2'h2, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
    endcase
    // page call / page jump column
    if (op[3:0] == 4'h1) begin
      d = mk(2'h2, 4'h4, 4'h4, 4'h6, 1'b0, itd_pkg::ITD_TGT_PAGE);
    end
    case (op)
      8'h00, `ITD_OP_SPARE: d = mk(2'h1, 4'h1, 4'h1, 4'h1, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h02, 8'h12: d = mk(2'h3, 4'h5, 4'h5, 4'h7, 1'b0, itd_pkg::ITD_TGT_LONG);
      8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hD4, 8'hA3, 8'h04, 8'h14, 8'hB3, 8'hC3, 8'hD3:
        d = mk(2'h1, 4'h1, 4'h1, 4'h1, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'hF4: d = mk(2'h1, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h10, 8'h20, 8'h30: d = mk(2'h3, 4'h3, 4'h5, 4'h7, 1'b1, itd_pkg::ITD_TGT_REL);
      8'h22, 8'h32: d = mk(2'h1, 4'h6, 4'h6, 4'h8, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h40, 8'h50, 8'h60, 8'h70: d = mk(2'h2, 4'h2, 4'h4, 4'h6, 1'b1, itd_pkg::ITD_TGT_REL);
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90:
        d = mk(2'h3, 4'h3, 4'h3, 4'h3, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h73: d = mk(2'h1, 4'h3, 4'h3, 4'h5, 1'b0, itd_pkg::ITD_TGT_IND);
      8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7: d = mk(2'h2, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h7F,
      8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F,
      8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF:
        d = mk(2'h2, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h80: d = mk(2'h2, 4'h4, 4'h4, 4'h6, 1'b0, itd_pkg::ITD_TGT_REL);
      8'h83: d = mk(2'h1, 4'h3, 4'h3, 4'h3, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h93: d = mk(2'h1, 4'h4, 4'h4, 4'h7, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'h84: d = mk(2'h1, 4'h8, 4'h8, 4'h8, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'hA4: d = mk(2'h1, 4'h4, 4'h4, 4'h4, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'hB4: d = mk(2'h3, 4'h3, 4'h6, 4'h8, 1'b1, itd_pkg::ITD_TGT_REL);
      8'hB5, 8'hB6, 8'hB7: d = mk(2'h3, 4'h4, 4'h6, 4'h8, 1'b1, itd_pkg::ITD_TGT_REL);
      8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF:
        d = mk(2'h3, 4'h3, 4'h5, 4'h7, 1'b1, itd_pkg::ITD_TGT_REL);
      8'hD5: d = mk(2'h3, 4'h3, 4'h5, 4'h7, 1'b1, itd_pkg::ITD_TGT_REL);
      8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF:
        d = mk(2'h2, 4'h2, 4'h4, 4'h6, 1'b1, itd_pkg::ITD_TGT_REL);
      8'hD6, 8'hD7: d = mk(2'h1, 4'h2, 4'h2, 4'h2, 1'b0, itd_pkg::ITD_TGT_NONE);
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
        d = mk(2'h1, 4'h3, 4'h3, 4'h3, 1'b0, itd_pkg::ITD_TGT_NONE);
      default: ;  // column default stands
    endcase
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////
  // state and next-state

  itd_pkg::itd_state_t st_r;        // all decoder state
  itd_pkg::itd_state_t st_nxt;      // next value
  itd_pkg::itd_info_t info;         // table entry of current opcode
  logic [15:0] next_pc;             // address of the following instruction
  logic [2:0] penalty;              // alignment plus flash wait slots
  logic [4:0] var_cyc;              // least count plus penalty
  logic [7:0] rel_off;              // chosen relative offset byte

  // combinational decode of the request
  always_comb begin
    info = decode(opcode_in);
    next_pc = pc_in + {14'h0000, info.len};
    penalty = {1'b0, align_in} + {1'b0, flash_read_timing_field_in};
    var_cyc = {1'b0, info.tmin} + {2'b00, penalty};
    rel_off = (info.len == 2'h3) ? op2_in : op1_in;
    st_nxt = st_r;
    st_nxt.valid = valid_in;
    if (valid_in) begin
      st_nxt.len = info.len;
      st_nxt.cyc_nt = info.nt;
      st_nxt.cyc_min = info.tmin;
      st_nxt.cyc_max = info.tmax;
      st_nxt.cond = info.cond;
      // not taken: fixed count; otherwise variable count saturates at most
      if (info.cond && !taken_in) begin
        st_nxt.cyc = info.nt;
      end else if (var_cyc > {1'b0, info.tmax}) begin
        st_nxt.cyc = info.tmax;
      end else begin
        st_nxt.cyc = var_cyc[3:0];
      end
      st_nxt.tgt_valid = (info.tgt != itd_pkg::ITD_TGT_NONE);
      // branch destination by target kind
      unique case (info.tgt)
        itd_pkg::ITD_TGT_REL: st_nxt.target = next_pc + {{8{rel_off[7]}}, rel_off};
        itd_pkg::ITD_TGT_PAGE: st_nxt.target = {next_pc[15:`ITD_PAGE_BITS], opcode_in[7:5], op1_in};
        itd_pkg::ITD_TGT_LONG: st_nxt.target = {op1_in, op2_in};
        itd_pkg::ITD_TGT_IND: st_nxt.target = data_pointer_pair_in + {8'h00, acc_in};
        itd_pkg::ITD_TGT_NONE: st_nxt.target = next_pc;
      endcase
      st_nxt.dir_sfr = op1_in[`ITD_DIR_SFR_BIT];
      st_nxt.bank_addr = {3'b000, bank_select_field_in, opcode_in[2:0]};
      st_nxt.ptr_addr = {3'b000, bank_select_field_in, 2'b00, opcode_in[0]};
      st_nxt.is_nop = (opcode_in == `ITD_OP_NOP) || (opcode_in == `ITD_OP_SPARE);
      st_nxt.nib_acc = {acc_in[7:4], mem_byte_in[3:0]};
      st_nxt.nib_mem = {mem_byte_in[7:4], acc_in[3:0]};
    end
  end

  // register the state, frozen while clock enable is low
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign valid_out = st_r.valid;
  assign len_out = st_r.len;
  assign cycles_out = st_r.cyc;
  assign cyc_nt_out = st_r.cyc_nt;
  assign cyc_min_out = st_r.cyc_min;
  assign cyc_max_out = st_r.cyc_max;
  assign cond_out = st_r.cond;
  assign tgt_valid_out = st_r.tgt_valid;
  assign target_out = st_r.target;
  assign dir_sfr_out = st_r.dir_sfr;
  assign bank_addr_out = st_r.bank_addr;
  assign ptr_addr_out = st_r.ptr_addr;
  assign nop_out = st_r.is_nop;
  assign nib_acc_out = st_r.nib_acc;
  assign nib_mem_out = st_r.nib_mem;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // next pc of a two-byte page transfer, kept apart from the decode path
  logic [15:0] pg_next;
  assign pg_next = pc_in + 16'h0002;

  // sampled request of the previous cycle
  sequence req_s(logic [7:0] op);
    ce_in && valid_in && opcode_in == op;
  endsequence

  a_spare_is_nop: assert property (req_s(8'hA5) |=> nop_out && len_out == 2'h1 && cycles_out == 4'h1)
    else $error("spare opcode not decoded as no-operation");
  a_cpl_two_cycles: assert property (req_s(8'hF4) |=> len_out == 2'h1 && cycles_out == 4'h2)
    else $error("accumulator complement count wrong");
  a_code_read_range: assert property (req_s(8'h93) |=> cyc_min_out == 4'h4 && cyc_max_out == 4'h7
      && cycles_out >= 4'h4 && cycles_out <= 4'h7)
    else $error("code read via data pointer out of range");
  a_xdata_three: assert property (ce_in && valid_in && opcode_in[7:5] == 3'h7 && opcode_in[3:2] == 2'b00
      && opcode_in[1:0] != 2'b01 |=> cycles_out == 4'h3 && len_out == 2'h1)
    else $error("external data move count wrong");
  a_not_taken_sooner: assert property (ce_in && valid_in && info.cond && !taken_in
      |=> cycles_out == cyc_nt_out && cyc_nt_out < cyc_min_out)
    else $error("not-taken count not below taken count");
  a_taken_in_range: assert property (ce_in && valid_in && taken_in && info.cond
      |=> cycles_out >= cyc_min_out && cycles_out <= cyc_max_out && cycles_out <= `ITD_MAX_CYCLES)
    else $error("taken count outside range");
  a_rel_target: assert property (req_s(8'h80) |=> target_out ==
      $past(pc_in) + 16'h0002 + {{8{$past(op1_in[7])}}, $past(op1_in)})
    else $error("relative target wrong");
  a_page_keeps_upper: assert property (ce_in && valid_in && opcode_in[3:0] == 4'h1
      |=> target_out[15:11] == $past(pg_next[15:11]) && target_out[10:8] == $past(opcode_in[7:5])
      && target_out[7:0] == $past(op1_in))
    else $error("page target left its page");
  a_long_target: assert property (req_s(8'h02) |=> target_out == {$past(op1_in), $past(op2_in)})
    else $error("long target wrong");
  a_direct_class: assert property (ce_in && valid_in |=> dir_sfr_out == ($past(op1_in) >= 8'h80))
    else $error("direct address class wrong");
  a_bank_addr_range: assert property (ce_in && valid_in |=> bank_addr_out[7:5] == 3'h0
      && bank_addr_out[4:3] == $past(bank_select_field_in))
    else $error("bank register address outside bank");
  a_nibble_swap: assert property (ce_in && valid_in && opcode_in[7:1] == 7'h6B |=> nib_acc_out[7:4] == $past(acc_in[7:4])
      && nib_acc_out[3:0] == $past(mem_byte_in[3:0])
      && nib_mem_out[3:0] == $past(acc_in[3:0]) && cycles_out == 4'h2)
    else $error("low nibble exchange wrong");
  a_cmp_imm_acc: assert property (ce_in && valid_in && opcode_in == 8'hB4 && taken_in |=> cyc_nt_out == 4'h3
      && cyc_min_out == 4'h6)
    else $error("compare immediate accumulator count wrong");
  // held results while the clock enable is low
  a_freeze: assert property (!ce_in |=> $stable(cycles_out) && $stable(target_out))
    else $error("state moved while clock enable low");

  // per-class byte and cycle counts
  a_xor_direct: assert property (req_s(8'h63) |=> len_out == 2'h3 && cycles_out == 4'h3)
    else $error("xor into direct count wrong");
  a_move_direct: assert property (req_s(8'h85) |=> len_out == 2'h3 && cycles_out == 4'h3)
    else $error("direct to direct move count wrong");
  a_pointer_load: assert property (req_s(8'h90) |=> len_out == 2'h3 && cycles_out == 4'h3)
    else $error("data pointer load count wrong");
  a_code_pc_read: assert property (req_s(8'h83) |=> len_out == 2'h1 && cycles_out == 4'h3)
    else $error("code read via pc count wrong");
  a_bit_clear_jump: assert property (req_s(8'h10) |=> cyc_nt_out == 4'h3 && cyc_max_out == 4'h7)
    else $error("jump bit and clear count wrong");
  a_long_count: assert property (req_s(8'h12) |=> len_out == 2'h3 && cyc_max_out == 4'h7)
    else $error("long call count wrong");
  a_return_count: assert property (req_s(8'h22) |=> cyc_min_out == 4'h6 && !tgt_valid_out)
    else $error("return count wrong");
  a_ind_jump: assert property (req_s(8'h73) |=> cyc_min_out == 4'h3 && cyc_max_out == 4'h5)
    else $error("indirect jump count wrong");
  a_cmp_bank_jump: assert property (req_s(8'hB8) |=> cyc_nt_out == 4'h3 && cyc_min_out == 4'h5)
    else $error("compare bank register count wrong");
  a_dec_bank_jump: assert property (req_s(8'hD8) |=> cyc_nt_out == 4'h2 && cyc_min_out == 4'h4)
    else $error("decrement bank register count wrong");

  // scenario covers
  c_taken_branch: cover property (ce_in && valid_in && taken_in && info.cond);
  c_not_taken: cover property (ce_in && valid_in && !taken_in && info.cond);
  c_frozen: cover property (!ce_in && valid_in);
  c_saturated: cover property (ce_in && valid_in && opcode_in == 8'h93 && align_in == 2'h3);
  c_spare: cover property (req_s(8'hA5));

endmodule : itd_core

// file: itd_fetch_model.sv
// itd_fetch_model.sv: program memory and data ram seen by the decoder
// assumes: the bench loads bytes with put and put_ram, before or after presenting the address
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module itd_fetch_model (
  input wire logic [15:0] pc_in,  // address of the opcode byte
  input wire logic [7:0] ram_addr_in,  // data ram address to read
  output logic [7:0] opcode_out,  // byte at pc
  output logic [7:0] op1_out,  // byte at pc+1
  output logic [7:0] op2_out,  // byte at pc+2
  output logic [7:0] mem_byte_out  // data ram byte
);
  logic [7:0] code_mem [logic [15:0]];  // sparse program memory
  logic [7:0] ram_mem [logic [7:0]];  // sparse data ram
  int loads = 0;  // count of loads, wakes the read process when contents change

  // unwritten places read as a pattern that moves with the address
  function automatic logic [7:0] itd_rd(input logic [15:0] a);
    return code_mem.exists(a) ? code_mem[a] : ~a[7:0];
  endfunction : itd_rd

  // load one instruction of up to three bytes
  task automatic put(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    code_mem[a] = b0;
    code_mem[a + 16'h0001] = b1;
    code_mem[a + 16'h0002] = b2;
    loads++;
  endtask : put

  // load one data ram byte
  task automatic put_ram(input logic [7:0] a, input logic [7:0] d);
    ram_mem[a] = d;
    loads++;
  endtask : put_ram

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous read of both memories
  always @(pc_in, ram_addr_in, loads) begin
    opcode_out = itd_rd(pc_in);
    op1_out = itd_rd(pc_in + 16'h0001);
    op2_out = itd_rd(pc_in + 16'h0002);
    mem_byte_out = ram_mem.exists(ram_addr_in) ? ram_mem[ram_addr_in] : ~ram_addr_in;
  end
endmodule : itd_fetch_model

// file: itd_pkg.sv
// itd_pkg.sv: types of the instruction length and timing decoder
// assumes: compiled before the decoder module
package itd_pkg;

  // kind of branch target the opcode produces
  typedef enum logic [2:0] {
    ITD_TGT_NONE,   // no computed target
    ITD_TGT_REL,    // signed offset from next instruction
    ITD_TGT_PAGE,   // low 11 bits replaced
    ITD_TGT_LONG,   // full 16-bit target
    ITD_TGT_IND     // accumulator plus data pointer
  } itd_tgt_t;

  // static timing of one opcode
  typedef struct packed {
    logic [1:0] len;     // byte count
    logic [3:0] nt;      // cycles when not taken (or fixed base)
    logic [3:0] tmin;    // least cycles when taken / variable
    logic [3:0] tmax;    // most cycles when taken / variable
    logic       cond;    // conditional branch
    itd_tgt_t   tgt;     // target kind
  } itd_info_t;

  // all registered state of the decoder
  typedef struct packed {
    logic        valid;      // decode result present
    logic [1:0]  len;        // byte length
    logic [3:0]  cyc;        // selected cycle count
    logic [3:0]  cyc_nt;     // not-taken count
    logic [3:0]  cyc_min;    // least taken count
    logic [3:0]  cyc_max;    // most taken count
    logic        cond;       // conditional branch
    logic        tgt_valid;  // target field meaningful
    logic [15:0] target;     // branch destination
    logic        dir_sfr;    // direct operand is a function register
    logic [7:0]  bank_addr;  // ram address of bank register operand
    logic [7:0]  ptr_addr;   // ram address of indirect pointer register
    logic        is_nop;     // no-operation (incl. spare opcode)
    logic [7:0]  nib_acc;    // accumulator after low nibble exchange
    logic [7:0]  nib_mem;    // ram byte after low nibble exchange
  } itd_state_t;

endpackage : itd_pkg

// file: testbench.sv
// testbench.sv: self-checking bench of the instruction length and timing decoder
// assumes: itd_pkg, itd_core and itd_fetch_model compiled before this file
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic mclk_in = 1'b0;  // system clock
  logic reset_in = 1'b1;  // async reset
  logic ce_v = 1'b1;  // clock enable
  logic valid_v = 1'b0;  // request strobe
  logic [15:0] pc_v = 16'h0000;  // opcode address
  logic taken_v = 1'b0;  // branch condition
  logic [1:0] align_v = 2'h0;  // alignment slots
  logic [1:0] flash_v = 2'h0;  // flash wait slots
  logic [1:0] bank_v = 2'h0;  // register bank
  logic [7:0] acc_v = 8'h00;  // accumulator
  logic [15:0] data_ptr_v = 16'h0000;  // data pointer
  logic [7:0] ram_addr_v = 8'h00;  // data ram address
  logic [7:0] opc, op1, op2, memb;  // model outputs
  logic valid_out, cond_out, tgt_valid_out, dir_sfr_out, nop_out;  // flags
  logic [1:0] len_out;  // byte length
  logic [3:0] cycles_out, cyc_nt_out, cyc_min_out, cyc_max_out;  // counts
  logic [15:0] target_out;  // destination
  logic [7:0] bank_addr_out, ptr_addr_out, nib_acc_out, nib_mem_out;  // addresses, nibbles
  int fails = 0;  // mismatches
  int comparisons = 0;  // checks made

  // fixed ops: opcode, bytes, cycles
  logic [15:0] fx [18] = '{16'hE411, 16'hF412, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411, 16'h6333,
    16'h8533, 16'h9033, 16'h8313, 16'hE013, 16'hE213, 16'hF013, 16'hF213, 16'hD612, 16'h0011, 16'hA511};
  // variable ops: opcode, bytes, not taken, least, most, conditional
  logic [27:0] vr [20] = '{28'h9310470, 28'h4022461, 28'h5022461, 28'h6022461, 28'h7022461, 28'h1033571,
    28'h1120460, 28'h0120460, 28'h8020460, 28'h1230570, 28'h0230570, 28'h2210680, 28'h3210680,
    28'h7310350, 28'hB534681, 28'hB634681, 28'hB433681, 28'hB833571, 28'hD533571, 28'hD822461};

  always #5 mclk_in = ~mclk_in;  // 100 MHz

  itd_fetch_model i_itd_fetch_model (.pc_in(pc_v), .ram_addr_in(ram_addr_v), .opcode_out(opc),
    .op1_out(op1), .op2_out(op2), .mem_byte_out(memb));

  itd_core #(.PC_W(16)) i_itd_core (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_v), .valid_in(valid_v),
    .opcode_in(opc), .op1_in(op1), .op2_in(op2), .pc_in(pc_v), .taken_in(taken_v), .align_in(align_v),
    .flash_read_timing_field_in(flash_v), .bank_select_field_in(bank_v), .acc_in(acc_v),
    .data_pointer_pair_in(data_ptr_v), .mem_byte_in(memb), .valid_out(valid_out), .len_out(len_out),
    .cycles_out(cycles_out), .cyc_nt_out(cyc_nt_out), .cyc_min_out(cyc_min_out), .cyc_max_out(cyc_max_out),
    .cond_out(cond_out), .tgt_valid_out(tgt_valid_out), .target_out(target_out), .dir_sfr_out(dir_sfr_out),
    .bank_addr_out(bank_addr_out), .ptr_addr_out(ptr_addr_out), .nop_out(nop_out),
    .nib_acc_out(nib_acc_out), .nib_mem_out(nib_mem_out));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // one compare for every result
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one request, answer one clock later
  task automatic issue(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    i_itd_fetch_model.put(a, b0, b1, b2);
    pc_v = a;
    valid_v = 1'b1;
    @(posedge mclk_in);
    #1;
    chk("valid_out", 16'h0001, {15'h0000, valid_out});
    valid_v = 1'b0;
    @(posedge mclk_in);
    #1;
    chk("valid_out", 16'h0000, {15'h0000, valid_out});
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////
  // fixed single-count ops and the spare opcode
  task automatic t_fixed();
    for (int i = 0; i < 18; i++) begin
      issue(16'h0200, fx[i][15:8], 8'h30, 8'h90);
      chk("len_out", {14'h0000, fx[i][5:4]}, {14'h0000, len_out});
      chk("cycles_out", {12'h000, fx[i][3:0]}, {12'h000, cycles_out});
      chk("nop_out", {15'h0000, fx[i][15:8] == 8'h00 || fx[i][15:8] == 8'hA5}, {15'h0000, nop_out});
    end
  endtask : t_fixed

  // variable and conditional ops under three penalty settings
  task automatic t_branch();
    logic [3:0] e;
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 20; i++) begin
        taken_v = (p != 0);
        align_v = (p == 0) ? 2'h0 : (p == 1) ? 2'h1 : 2'h3;
        flash_v = (p == 2) ? 2'h3 : 2'h0;
        e = (p == 2) ? vr[i][7:4] : (p == 1) ? vr[i][11:8] + 4'h1 : (vr[i][0] ? vr[i][15:12] : vr[i][11:8]);
        issue(16'h0400, vr[i][27:20], 8'h20, 8'h05);
        chk("cycles_out", {12'h000, e}, {12'h000, cycles_out});
        chk("len_out", {14'h0000, vr[i][17:16]}, {14'h0000, len_out});
        chk("cyc_min_out", {12'h000, vr[i][11:8]}, {12'h000, cyc_min_out});
        chk("cyc_max_out", {12'h000, vr[i][7:4]}, {12'h000, cyc_max_out});
        chk("cond_out", {15'h0000, vr[i][0]}, {15'h0000, cond_out});
        chk("cyc_nt_out", {12'h000, vr[i][0] ? vr[i][15:12] : vr[i][11:8]}, {12'h000, cyc_nt_out});
      end
    end
    taken_v = 1'b0;
    align_v = 2'h0;
    flash_v = 2'h0;
  endtask : t_branch

  // destinations of relative, page, long and indirect transfers
  task automatic t_target();
    issue(16'h1000, 8'h80, 8'hFE, 8'h00);
    chk("target_out", 16'h1000, target_out);
    issue(16'h0010, 8'h10, 8'h20, 8'h80);
    chk("target_out", 16'hFF93, target_out);
    issue(16'h1FFE, 8'h11, 8'h34, 8'h00);
    chk("target_out", 16'h2034, target_out);
    issue(16'h0100, 8'h02, 8'hBE, 8'hEF);
    chk("target_out", 16'hBEEF, target_out);
    chk("tgt_valid_out", 16'h0001, {15'h0000, tgt_valid_out});
    acc_v = 8'h10;
    data_ptr_v = 16'hFFF8;
    issue(16'h0300, 8'h73, 8'h00, 8'h00);
    chk("target_out", 16'h0008, target_out);
  endtask : t_target

  // operand addresses and the low nibble exchange
  task automatic t_addr();
    issue(16'h0500, 8'hE5, 8'h7F, 8'h00);
    chk("dir_sfr_out", 16'h0000, {15'h0000, dir_sfr_out});
    issue(16'h0500, 8'hE5, 8'h80, 8'h00);
    chk("dir_sfr_out", 16'h0001, {15'h0000, dir_sfr_out});
    for (int b = 0; b < 4; b++) begin
      bank_v = b[1:0];
      issue(16'h0600, 8'hEB, 8'h00, 8'h00);
      chk("bank_addr_out", 16'h0003 + 16'(b * 8), {8'h00, bank_addr_out});
    end
    bank_v = 2'h2;
    acc_v = 8'h3C;
    ram_addr_v = 8'h11;
    i_itd_fetch_model.put_ram(8'h11, 8'h96);
    issue(16'h0700, 8'hD7, 8'h00, 8'h00);
    chk("ptr_addr_out", 16'h0011, {8'h00, ptr_addr_out});
    chk("nib_acc_out", 16'h0036, {8'h00, nib_acc_out});
    chk("nib_mem_out", 16'h009C, {8'h00, nib_mem_out});
  endtask : t_addr

  // clock enable low holds the target and cycle count, even with a new request present
  task automatic t_freeze();
    issue(16'h0800, 8'h80, 8'h10, 8'h00);
    ce_v = 1'b0;
    i_itd_fetch_model.put(16'h0800, 8'h02, 8'h12, 8'h34);
    valid_v = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("target_out", 16'h0812, target_out);
    chk("cycles_out", 16'h0004, {12'h000, cycles_out});
    ce_v = 1'b1;
    valid_v = 1'b0;
    @(posedge mclk_in);
    #1;
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge mclk_in);
    #1;
    chk("valid_out", 16'h0000, {15'h0000, valid_out});
    chk("target_out", 16'h0000, target_out);
    reset_in = 1'b0;
    @(posedge mclk_in);
    #1;
    t_fixed();
    t_branch();
    t_target();
    t_addr();
    t_freeze();
    test_done();
  end

  // hang guard
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule : testbench
